/* File: hw/srw_pkg.sv */
// Package for the serial relay word link: widths, timing counts, bit positions.
// Assumes a 50 MHz system clock on both ends.
package srw_pkg;
  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS   = 24;
  localparam int RELAY_COUNT = 19;
  localparam int CNT_W       = 5;
  localparam int CNT_W8_BIT  = 3;
  localparam int CNT_W16_BIT = 4;
  localparam logic [WORD_BITS-1:0] WORD_RESET = 24'h000000;
  // Tune relay positions in the relay vector (index = relay number - 1)
  localparam int TUNE_A_BIT = 18;
  localparam int TUNE_B_BIT = 16;
  localparam int TUNE_C_BIT = 7;
  localparam int TUNE_D_BIT = 1;
  localparam int MANUAL_BIT = 0;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ            = 50_000_000;
  localparam int HOLD_MIN_US       = 2930;
  localparam int HOLD_MAX_US       = 3780;
  localparam int HOLD_US           = 3000;
  localparam int HOLD_CYC          = HOLD_US * (CLK_HZ / 1_000_000);
  localparam int RST_PULSE_NS      = 10000;
  localparam int RST_PULSE_CYC     = (RST_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int TUNE_DET_US       = 50000;
  localparam int TUNE_DET_CYC      = TUNE_DET_US * (CLK_HZ / 1_000_000);
  localparam int GAP_US            = 4000;
  localparam int GAP_CYC           = GAP_US * (CLK_HZ / 1_000_000);
  localparam int INTERVAL_US       = 3200;
  localparam int INTERVAL_CYC      = INTERVAL_US * (CLK_HZ / 1_000_000);
  localparam int LINK_HALF_CYC     = 4;
  localparam int TMR_W             = 24;
endpackage

/* File: hw/srw_link_if.sv */
// Interface joining the word sender and the relay word receiver.
// Both lines are driven only by the sender; the receiver samples them.
`timescale 1ns/1ps
interface srw_link_if;
  logic link_clk;   // One pulse per data bit
  logic link_data;  // Serial data, equal to TUNE_I when idle
  modport sender   (output link_clk, output link_data);
  modport receiver (input link_clk, input link_data);
endinterface

/* File: hw/srw_receiver.sv */
// Relay word receiver: shifts 24 link bits, latches the low 19 onto relay drivers,
// times the counter reset between the two trains and detects manual tune.
// Assumes link lines are asynchronous to CLK_SYS_I and much slower than it.
`timescale 1ns/1ps
module srw_receiver #(
  parameter int HOLD_CYC     = srw_pkg::HOLD_CYC,     // Strobe hold length
  parameter int RST_CYC      = srw_pkg::RST_PULSE_CYC, // Counter reset length
  parameter int TUNE_DET_CYC = srw_pkg::TUNE_DET_CYC  // Manual tune delay
) (
  input  wire logic                          CLK_SYS_I,    // System clock
  input  wire logic                          RSTN_I,       // Async reset, low
  srw_link_if.receiver                       link,         // Link from sender
  output logic [srw_pkg::RELAY_COUNT-1:0]    RELAY_O,      // Relay drivers
  output logic                               MANUAL_TUNE_O,// Manual tune mode
  output logic                               STROBE_O      // Latch strobe level
);
  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [1:0] clk_sync;
  logic [1:0] data_sync;
  logic       clk_prev;
  logic       clk_rise;

  // Two flops per pin; only the second stage feeds logic
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      clk_sync  <= 2'h0;
      data_sync <= 2'h0;
      clk_prev  <= 1'b0;
    end else begin
      clk_sync  <= {clk_sync[0], link.link_clk};
      data_sync <= {data_sync[0], link.link_data};
      clk_prev  <= clk_sync[1];
    end
  end

  assign clk_rise = clk_sync[1] & ~clk_prev;

  // ----------------------------------------------------------------
  // Shift register and pulse counter
  // ----------------------------------------------------------------
  logic [srw_pkg::WORD_BITS-1:0] shift_word;
  logic [srw_pkg::CNT_W-1:0]     clock_pulse_counter;
  logic                          counter_clear;
  logic                          strobe;

  // Data enters only on a link clock edge; 24 bits fill the whole shift register
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      shift_word <= srw_pkg::WORD_RESET;
    end else if (clk_rise) begin
      shift_word <= {shift_word[srw_pkg::WORD_BITS-2:0], data_sync[1]};
    end
  end

  // Counter stops at 24 so stray pulses cannot roll the strobe over
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      clock_pulse_counter <= '0;
    end else if (counter_clear) begin
      clock_pulse_counter <= '0;
    end else if (clk_rise && !strobe) begin
      clock_pulse_counter <= clock_pulse_counter + 5'h01;
    end
  end

  // Weight eight and sixteen both high means the 24th pulse
  assign strobe = clock_pulse_counter[srw_pkg::CNT_W8_BIT]
                & clock_pulse_counter[srw_pkg::CNT_W16_BIT];

  // ----------------------------------------------------------------
  // Strobe hold and counter reset timers
  // ----------------------------------------------------------------
  logic                    strobe_prev;
  logic                    strobe_rise;
  logic [srw_pkg::TMR_W-1:0] strobe_hold_timer;
  logic                    hold_active;
  logic                    hold_prev;
  logic [srw_pkg::TMR_W-1:0] counter_reset_timer;
  logic                    powerup;

  assign strobe_rise = strobe & ~strobe_prev;
  assign hold_active = (strobe_hold_timer != '0);

  // Hold pulse rises with the strobe and lasts the hold time
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      strobe_prev       <= 1'b0;
      strobe_hold_timer <= '0;
      hold_prev         <= 1'b0;
    end else begin
      strobe_prev <= strobe;
      hold_prev   <= hold_active;
      if (strobe_rise) begin
        strobe_hold_timer <= srw_pkg::TMR_W'(HOLD_CYC);
      end else if (hold_active) begin
        strobe_hold_timer <= strobe_hold_timer - 24'h000001;
      end
    end
  end

  // Reset pulse fires at power-up and on the hold falling edge
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      powerup             <= 1'b1;
      counter_reset_timer <= '0;
    end else begin
      powerup <= 1'b0;
      if (powerup || (hold_prev && !hold_active)) begin
        counter_reset_timer <= srw_pkg::TMR_W'(RST_CYC);
      end else if (counter_clear) begin
        counter_reset_timer <= counter_reset_timer - 24'h000001;
      end
    end
  end

  assign counter_clear = (counter_reset_timer != '0);

  // ----------------------------------------------------------------
  // Manual tune detector
  // ----------------------------------------------------------------
  logic [srw_pkg::TMR_W-1:0] tune_timer;
  logic                      manual_tune;

  // Data must differ from the current mode for the full delay to flip it;
  // the slow filter means a normal word can never trip it
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tune_timer  <= '0;
      manual_tune <= 1'b0;
    end else if (data_sync[1] == manual_tune) begin
      tune_timer <= '0;
    end else if (tune_timer == srw_pkg::TMR_W'(TUNE_DET_CYC - 1)) begin
      tune_timer  <= '0;
      manual_tune <= ~manual_tune;
    end else begin
      tune_timer <= tune_timer + 24'h000001;
    end
  end

  // ----------------------------------------------------------------
  // Latch and relay drivers
  // ----------------------------------------------------------------
  logic [srw_pkg::RELAY_COUNT-1:0] latch_word;
  logic [srw_pkg::RELAY_COUNT-1:0] next_relay;

  // Latch on strobe; upper word bits beyond 19 relays are unused
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      latch_word <= '0;
    end else if (strobe) begin
      latch_word <= shift_word[srw_pkg::RELAY_COUNT-1:0];
    end
  end

  // Manual tune drops driver outputs and forces the 2182 kHz set
  always_comb begin
    next_relay = latch_word;
    if (manual_tune) begin
      next_relay                     = '0;
      next_relay[srw_pkg::MANUAL_BIT] = 1'b1;
      next_relay[srw_pkg::TUNE_A_BIT] = 1'b1;
      next_relay[srw_pkg::TUNE_B_BIT] = 1'b1;
      next_relay[srw_pkg::TUNE_C_BIT] = 1'b1;
      next_relay[srw_pkg::TUNE_D_BIT] = 1'b1;
    end
  end

  // Registered outputs
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RELAY_O       <= '0;
      MANUAL_TUNE_O <= 1'b0;
      STROBE_O      <= 1'b0;
    end else begin
      RELAY_O       <= next_relay;
      MANUAL_TUNE_O <= manual_tune;
      STROBE_O      <= strobe;
    end
  end
endmodule

/* File: hw/srw_sender.sv */
// Word sender: sends each 24-bit word twice over clock and data lines,
// keeping data at the TUNE_I level when idle. The link clock is divided from CLK_SYS_I.
// Assumes WORD_I is valid in the cycle SEND_I is taken; it is registered then.
`timescale 1ns/1ps
module srw_sender #(
  parameter int GAP_CYC      = srw_pkg::GAP_CYC,      // Last clock fall to 2nd train
  parameter int INTERVAL_CYC = srw_pkg::INTERVAL_CYC, // Train pacing
  parameter int HALF_CYC     = srw_pkg::LINK_HALF_CYC // Link clock half period
) (
  input  wire logic                             CLK_SYS_I,  // System clock
  input  wire logic                             RSTN_I,     // Async reset, low
  input  wire logic                             SEND_I,     // Start pulse
  input  wire logic [srw_pkg::WORD_BITS-1:0]    WORD_I,     // Word to send
  input  wire logic                             TUNE_I,     // Hold data high
  output logic                                  BUSY_O,     // Transfer running
  srw_link_if.sender                            link        // Link to receiver
);
  typedef enum logic [3:0] {
    SRW_IDLE  = 4'h1,
    SRW_SHIFT = 4'h2,
    SRW_GAP   = 4'h4,
    SRW_DONE  = 4'h8
  } srw_state_t;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  srw_state_t              state;
  logic [srw_pkg::TMR_W-1:0] timer;
  logic [4:0]              bit_idx;
  logic                    second;
  logic                    phase;
  logic [srw_pkg::WORD_BITS-1:0] word;

  // Trains are 24 bits MSB first; gap measured from the last clock edge
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state          <= SRW_IDLE;
      timer          <= '0;
      bit_idx        <= 5'h00;
      second         <= 1'b0;
      phase          <= 1'b0;
      word           <= '0;
      link.link_clk  <= 1'b0;
      link.link_data <= 1'b0;
      BUSY_O         <= 1'b0;
    end else begin
      case (state)
        SRW_IDLE: begin
          link.link_clk  <= 1'b0;
          link.link_data <= TUNE_I;
          if (SEND_I && !TUNE_I) begin
            word           <= WORD_I;
            bit_idx        <= 5'h00;
            second         <= 1'b0;
            phase          <= 1'b0;
            timer          <= srw_pkg::TMR_W'(HALF_CYC);
            link.link_data <= WORD_I[srw_pkg::WORD_BITS-1];
            BUSY_O         <= 1'b1;
            state          <= SRW_SHIFT;
          end
        end
        SRW_SHIFT: begin
          if (timer != '0) begin
            timer <= timer - 24'h000001;
          end else if (!phase) begin
            link.link_clk <= 1'b1;
            phase         <= 1'b1;
            timer         <= srw_pkg::TMR_W'(HALF_CYC);
          end else begin
            link.link_clk <= 1'b0;
            phase         <= 1'b0;
            timer         <= srw_pkg::TMR_W'(HALF_CYC);
            if (bit_idx == 5'(srw_pkg::WORD_BITS - 1)) begin
              link.link_data <= 1'b0;
              if (second) begin
                timer <= srw_pkg::TMR_W'(INTERVAL_CYC);
                state <= SRW_DONE;
              end else begin
                timer <= srw_pkg::TMR_W'(GAP_CYC);
                state <= SRW_GAP;
              end
            end else begin
              bit_idx        <= bit_idx + 5'h01;
              link.link_data <= word[5'(srw_pkg::WORD_BITS - 2) - bit_idx];
            end
          end
        end
        SRW_GAP: begin
          if (timer != '0) begin
            timer <= timer - 24'h000001;
          end else begin
            second         <= 1'b1;
            bit_idx        <= 5'h00;
            timer          <= srw_pkg::TMR_W'(HALF_CYC);
            link.link_data <= word[srw_pkg::WORD_BITS-1];
            state          <= SRW_SHIFT;
          end
        end
        SRW_DONE: begin
          if (timer != '0) begin
            timer <= timer - 24'h000001;
          end else begin
            BUSY_O <= 1'b0;
            state  <= SRW_IDLE;
          end
        end
        default: state <= SRW_IDLE;
      endcase
    end
  end
endmodule

/* File: bench/srw_link_properties.sv */
// Concurrent checks on the relay word link and on the receiver's outputs.
// Assumes instantiation beside the link interface with the receiver's parameters.
`timescale 1ns/1ps
module srw_link_properties #(
  parameter int HOLD_CYC     = 200, // Strobe hold length
  parameter int RST_CYC      = 5,   // Counter reset length
  parameter int TUNE_DET_CYC = 300  // Manual tune delay
) (
  input wire logic                           CLK_SYS_I,     // System clock
  input wire logic                           RSTN_I,        // Async reset, low
  input wire logic                           link_clk,      // Link clock
  input wire logic                           link_data,     // Link data
  input wire logic [srw_pkg::RELAY_COUNT-1:0] RELAY_O,      // Relay drivers
  input wire logic                           MANUAL_TUNE_O, // Manual tune mode
  input wire logic                           STROBE_O       // Latch strobe
);
  logic        clk_q;
  logic        strobe_q;
  logic [4:0]  pulses;
  logic [15:0] hold_cnt;
  logic [15:0] run_cnt;
  logic        data_q;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  // Raw link pulses since reset or the last fall of STROBE_O; saturates so strays cannot wrap
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      clk_q <= 1'b0;
      strobe_q <= 1'b0;
      pulses <= 5'h00;
    end else begin
      clk_q <= link_clk;
      strobe_q <= STROBE_O;
      if (strobe_q && !STROBE_O) pulses <= 5'h00;
      else if (link_clk && !clk_q && pulses != 5'h1f) pulses <= pulses + 5'h01;
    end
  end
  // Length of the current strobe, and of the current unchanged data level
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      hold_cnt <= 16'h0000;
      run_cnt <= 16'h0000;
      data_q <= 1'b0;
    end else begin
      hold_cnt <= STROBE_O ? hold_cnt + 16'h0001 : 16'h0000;
      data_q <= link_data;
      if (link_data != data_q) run_cnt <= 16'h0000;
      else if (run_cnt != 16'hffff) run_cnt <= run_cnt + 16'h0001;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  strobe_count_a: assert property ($rose(STROBE_O) |-> pulses == 5'h18)
    else $error("strobe without 24 link pulses");
  strobe_after_24_a: assert property (
    (link_clk && !clk_q && pulses == 5'h17) |-> ##[3:9] $rose(STROBE_O))
    else $error("no strobe after 24th pulse");
  strobe_hold_a: assert property ($fell(STROBE_O) |->
    hold_cnt >= HOLD_CYC && hold_cnt <= HOLD_CYC + RST_CYC + 4)
    else $error("strobe hold length wrong");
  data_stable_a: assert property ($rose(link_clk) |-> $stable(link_data)[*4])
    else $error("data moved while link clock high");
  relay_on_strobe_a: assert property (
    ($changed(RELAY_O) && !MANUAL_TUNE_O && !$past(MANUAL_TUNE_O))
    |-> $past(STROBE_O) && !$past(STROBE_O, 2))
    else $error("relays changed without strobe");
  tune_relays_a: assert property (MANUAL_TUNE_O |-> RELAY_O == 19'h50083)
    else $error("tune relay pattern wrong");
  tune_entry_a: assert property ($rose(MANUAL_TUNE_O) |-> link_data &&
    run_cnt >= TUNE_DET_CYC && run_cnt <= TUNE_DET_CYC + 8)
    else $error("manual tune entered at wrong time");
  tune_exit_a: assert property ($fell(MANUAL_TUNE_O) |-> !link_data &&
    run_cnt >= TUNE_DET_CYC && run_cnt <= TUNE_DET_CYC + 8)
    else $error("manual tune left at wrong time");
endmodule

/* File: bench/srw_receiver_tb.sv */
// Testbench: sender and receiver joined by the link interface, words and tune.
// Assumes shortened timing parameters; the checker watches the link.
`timescale 1ns/1ps
module srw_receiver_tb;
  localparam int DET  = 300;
  localparam int HOLD = 200; // Receiver hold, shortened
  localparam int RST  = 5;   // Receiver counter reset, shortened
  // Train gap and word spacing must exceed HOLD + RST, else the next
  // word's first pulses land while the counter is still saturated
  localparam int GAP  = 260;
  localparam logic [23:0] WORDS [3] = '{24'hf80001, 24'h07fffe, 24'h2aaaaa};
  logic        clk;
  logic        rstn;
  logic        send;
  logic        tune;
  logic        busy;
  logic        manual;
  logic        strobe;
  logic [23:0] word;
  logic [18:0] relay;
  int          n_errors;
  int          checks;
  int          strobes;
  srw_link_if srw_link_if_i ();
  srw_sender #(.GAP_CYC(GAP), .INTERVAL_CYC(GAP)) srw_sender_i (
    .CLK_SYS_I(clk), .RSTN_I(rstn), .SEND_I(send), .WORD_I(word), .TUNE_I(tune),
    .BUSY_O(busy), .link(srw_link_if_i.sender));
  srw_receiver #(.HOLD_CYC(HOLD), .RST_CYC(RST), .TUNE_DET_CYC(DET)) srw_receiver_i (
    .CLK_SYS_I(clk), .RSTN_I(rstn), .link(srw_link_if_i.receiver), .RELAY_O(relay),
    .MANUAL_TUNE_O(manual), .STROBE_O(strobe));
  srw_link_properties #(.HOLD_CYC(HOLD), .RST_CYC(RST), .TUNE_DET_CYC(DET))
    srw_link_properties_i (.CLK_SYS_I(clk), .RSTN_I(rstn),
    .link_clk(srw_link_if_i.link_clk), .link_data(srw_link_if_i.link_data),
    .RELAY_O(relay), .MANUAL_TUNE_O(manual), .STROBE_O(strobe));
  // ----------------------------------------------------------------
  // Clock, strobe count and tasks
  // ----------------------------------------------------------------
  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Counting rises catches a second train that never latched
  always @(posedge strobe) strobes++;
  task automatic test_done();
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check_val(input logic [23:0] got, input logic [23:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Bounded wait on busy (sel 0) or manual (sel 1); sampled 1 ns after the edge
  task automatic wait_sig(input bit sel, input logic lvl, input int bound);
    for (int i = 0; i < bound; i++) begin
      @(posedge clk);
      #1;
      if ((sel ? manual : busy) === lvl) return;
    end
    n_errors++;
    $display("MISMATCH %0t: wait timed out", $time);
    test_done();
  endtask
  task automatic send_word(input logic [23:0] w);
    @(posedge clk);
    send <= 1'b1;
    word <= w;
    @(posedge clk);
    send <= 1'b0;
    wait_sig(1'b0, 1'b1, 10);
    wait_sig(1'b0, 1'b0, 4000);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    send = 1'b0;
    tune = 1'b0;
    word = 24'h000000;
    n_errors = 0;
    checks = 0;
    strobes = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    // Power-up counter clear must end before the first pulse
    repeat (20) @(posedge clk);
    #1 check_val(24'(relay), 24'h000000, "relays after reset");
    foreach (WORDS[k]) begin
      strobes = 0;
      send_word(WORDS[k]);
      check_val(24'(relay), 24'(WORDS[k][18:0]), "relays");
      check_val(24'(strobes), 24'h000002, "strobes per send");
    end
    // A short high excursion must not enter tune
    @(posedge clk);
    tune <= 1'b1;
    repeat (100) @(posedge clk);
    tune <= 1'b0;
    repeat (DET + 20) @(posedge clk);
    #1 check_val(24'(manual), 24'h000000, "short high ignored");
    @(posedge clk);
    tune <= 1'b1;
    repeat (DET - 10) @(posedge clk);
    #1 check_val(24'(manual), 24'h000000, "tune too early");
    wait_sig(1'b1, 1'b1, 40);
    check_val(24'(relay), 24'h050083, "tune relays");
    @(posedge clk);
    tune <= 1'b0;
    repeat (DET - 10) @(posedge clk);
    #1 check_val(24'(manual), 24'h000001, "tune left too early");
    wait_sig(1'b1, 1'b0, 40);
    check_val(24'(relay), 24'(WORDS[2][18:0]), "relays resume");
    test_done();
  end
endmodule
